// *** design/fet_defines.svh ***
/*
  timing, geometry and data constants of the embedded operation sequencer.
  assumes a single 100 MHz system clock; included by bare name.
*/
`ifndef FET_DEFINES_SVH
`define FET_DEFINES_SVH

`define FET_CLK_KHZ 100000
`define FET_CLK_NS 10
`define FET_ERASE_MS 3500
`define FET_PROG_US 1050
`define FET_SECT_PROG_MS 269
`define FET_EES_US 30
`define FET_SUSP_US 50
`define FET_RESUME_GAP_NS 60
`define FET_BUF_WORDS 256
`define FET_SECTOR_WORDS 65536
`define FET_PREPROG_DATA 16'h0000
`define FET_ADDR_W 26
`define FET_TMR_W 32

`endif

// *** design/fet_pkg.sv ***
/*
  types of the embedded operation sequencer.
  assumes nothing beyond the defines header.
*/
package fet_pkg;

  typedef enum logic [3:0] {
    OP_WORD,
    OP_BUF,
    OP_ERASE,
    OP_EVAL,
    OP_NVR,
    OP_OTP,
    OP_SUSPEND,
    OP_RESUME
  } fet_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREPROG,
    ST_ERASE,
    ST_PROG,
    ST_EVAL,
    ST_SUSP
  } fet_state_t;

endpackage

// *** design/fet_timer_if.sv ***
/*
  carrier between the sequencer and its algorithm timer.
  assumes both ends share clk_sys.
*/
`timescale 1ns/10ps
`include "fet_defines.svh"

interface fet_timer_if;
  logic load;
  logic [`FET_TMR_W-1:0] load_val;
  logic pause;
  logic zero;

  modport seq (output load, output load_val, output pause, input zero);
  modport tmr (input load, input load_val, input pause, output zero);
endinterface

// *** design/fet_timer.sv ***
/*
  down counter timing one embedded algorithm, frozen while paused.
  assumes load is a one-cycle pulse from the sequencer on the same clock.
*/
`timescale 1ns/10ps
`include "fet_defines.svh"

module fet_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // sequencer side
  fet_timer_if.tmr tp
);

  logic [`FET_TMR_W-1:0] cnt;
  logic zero;
  wire logic [`FET_TMR_W-1:0] next_cnt;

  assign next_cnt = tp.load ? tp.load_val :
                    (tp.pause || cnt == '0) ? cnt : cnt - `FET_TMR_W'h1;
  assign tp.zero = zero;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      zero <= 1'b1;
    end else begin
      cnt <= next_cnt;
      zero <= (next_cnt == '0);
    end
  end

endmodule // fet_timer

// *** design/fet_seq.sv ***
/*
  embedded program / erase / status-evaluation sequencer with suspend and resume.
  assumes commands arrive already decoded, as one-cycle strobes from logic on clk_sys.
*/
// Operation
// - a sector erase, pre-programming included, ends within 3500 ms.
// - an erase first programs every word of the sector to zero and only then erases.
// - a single-word program ends within 1050 us of its command.
// - a buffered program of up to 512 bytes ends within 1050 us; in byte mode a full 256-word buffer is refused instead.
// - a whole sector of full-buffer programs takes at most 269 ms of algorithm time.
// - after an accepted suspend the running operation stops and the device is ready within 50 us.
// - the erase-status evaluation ends within 30 us.
// - every non-volatile register write costs one cycle of the whole register array.
// - one-time-programmable writes live in a separate array and cost no cycle.
`timescale 1ns/10ps
`include "fet_defines.svh"

module fet_seq
  import fet_pkg::*;
#(
  parameter int ADDR_W = `FET_ADDR_W,
  parameter int SECTOR_WORDS = `FET_SECTOR_WORDS,
  parameter logic [31:0] ERASE_CYC = 32'(`FET_ERASE_MS * `FET_CLK_KHZ),
  parameter logic [31:0] PROG_CYC = 32'(`FET_PROG_US * `FET_CLK_KHZ / 1000),
  parameter logic [31:0] SECT_PROG_CYC = 32'(`FET_SECT_PROG_MS * `FET_CLK_KHZ),
  parameter logic [31:0] SUSP_CYC = 32'(`FET_SUSP_US * `FET_CLK_KHZ / 1000)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // decoded command strobe
  input wire logic cmd_valid,
  input wire fet_op_t cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [8:0] cmd_words,
  input wire logic byte_mode,
  // status
  output logic busy,
  output logic suspended,
  output logic op_done,
  output logic cmd_reject,
  // array pre-programming and erase
  output logic preprog_valid,
  output logic [ADDR_W-1:0] preprog_addr,
  output logic [15:0] preprog_data,
  output logic erase_active,
  // wear accounting
  output logic [31:0] nvr_pe_count
);

  localparam logic [31:0] EES_CYC = 32'(`FET_EES_US * `FET_CLK_KHZ / 1000);
  localparam logic [3:0] GAP_CYC = 4'((`FET_RESUME_GAP_NS + `FET_CLK_NS - 1) / `FET_CLK_NS);
  localparam logic [ADDR_W-1:0] SECT_MASK = ADDR_W'(SECTOR_WORDS - 1);

  function automatic logic [31:0] cyc_load(input logic [31:0] n);
    return n - 32'h1;
  endfunction

  fet_timer_if tif();

  fet_timer u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tp(tif.tmr)
  );

  fet_state_t state;
  fet_state_t next_state;
  fet_state_t saved;
  logic [ADDR_W-1:0] sect_base;
  logic [ADDR_W-1:0] pre_idx;
  logic [3:0] gap_cnt;
  logic timer_armed;

  wire logic is_idle = (state == ST_IDLE);
  wire logic is_work = (cmd_op == OP_WORD) || (cmd_op == OP_BUF) || (cmd_op == OP_ERASE) ||
                       (cmd_op == OP_EVAL) || (cmd_op == OP_NVR) || (cmd_op == OP_OTP);
  // oversize or full buffer in byte mode is refused, not truncated
  wire logic bad_buf = (cmd_op == OP_BUF) &&
                       (cmd_words > 9'(`FET_BUF_WORDS) || cmd_words == 9'h0 ||
                        (byte_mode && cmd_words == 9'(`FET_BUF_WORDS)));
  wire logic start_ok = cmd_valid && is_idle && is_work && !bad_buf;
  wire logic tmr_end = tif.zero && timer_armed;
  wire logic ends = tmr_end && ((state == ST_ERASE) || (state == ST_PROG) || (state == ST_EVAL));
  wire logic susp_able = (state == ST_PREPROG) || (state == ST_ERASE) || (state == ST_PROG);
  // too-early suspend is dropped so progress is guaranteed; one landing on the last cycle is moot
  wire logic susp_ok = cmd_valid && (cmd_op == OP_SUSPEND) && susp_able && (gap_cnt == 4'h0) && !ends;
  wire logic res_ok = cmd_valid && (cmd_op == OP_RESUME) && (state == ST_SUSP);
  wire logic next_reject = cmd_valid && !(start_ok || susp_ok || res_ok);
  wire logic pre_last = ((pre_idx & SECT_MASK) == SECT_MASK);

  // resume never reloads: the frozen remainder carries on
  assign tif.load = start_ok;
  assign tif.pause = (state == ST_SUSP);
  assign tif.load_val = (cmd_op == OP_ERASE) ? cyc_load(ERASE_CYC) :
                        (cmd_op == OP_EVAL) ? cyc_load(EES_CYC) :
                        cyc_load(PROG_CYC);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          case (cmd_op)
            OP_ERASE: next_state = ST_PREPROG;
            OP_EVAL: next_state = ST_EVAL;
            default: next_state = ST_PROG;
          endcase
        end
      end
      ST_PREPROG: begin
        if (susp_ok) next_state = ST_SUSP;
        else if (pre_last) next_state = ST_ERASE;
      end
      ST_ERASE, ST_PROG: begin
        if (susp_ok) next_state = ST_SUSP;
        else if (ends) next_state = ST_IDLE;
      end
      ST_EVAL: begin
        if (ends) next_state = ST_IDLE;
      end
      ST_SUSP: begin
        if (res_ok) next_state = saved;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      saved <= ST_IDLE;
      timer_armed <= 1'b0;
    end else begin
      state <= next_state;
      if (susp_ok) saved <= state;
      timer_armed <= !tif.load;
    end
  end

  // resume reloads gap_cnt with GAP_CYC, holding off a new suspend; the timer is not reloaded
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap_cnt <= 4'h0;
    end else if (res_ok) begin
      gap_cnt <= GAP_CYC;
    end else if (gap_cnt != 4'h0) begin
      gap_cnt <= gap_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sect_base <= '0;
      pre_idx <= '0;
    end else if (start_ok && cmd_op == OP_ERASE) begin
      sect_base <= cmd_addr & ~SECT_MASK;
      pre_idx <= '0;
    end else if (state == ST_PREPROG && next_state == ST_PREPROG) begin
      pre_idx <= pre_idx + ADDR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      suspended <= 1'b0;
      op_done <= 1'b0;
      cmd_reject <= 1'b0;
      preprog_valid <= 1'b0;
      preprog_addr <= '0;
      preprog_data <= `FET_PREPROG_DATA;
      erase_active <= 1'b0;
      nvr_pe_count <= 32'h0;
    end else begin
      busy <= (next_state != ST_IDLE) && (next_state != ST_SUSP);
      suspended <= (next_state == ST_SUSP);
      op_done <= ends && !susp_ok;
      cmd_reject <= next_reject;
      preprog_valid <= (state == ST_PREPROG) && !susp_ok;
      preprog_addr <= sect_base | (pre_idx & SECT_MASK);
      preprog_data <= `FET_PREPROG_DATA;
      // lags a cycle so it never overlaps the last pre-program word
      erase_active <= (state == ST_ERASE) && (next_state == ST_ERASE);
      // whole register array wears on any register write; otp array does not
      if (start_ok && cmd_op == OP_NVR) nvr_pe_count <= nvr_pe_count + 32'h1;
    end
  end

  // checking helpers: active (unsuspended) cycles of the current operation
  logic [31:0] act_cnt;
  fet_op_t cur_op;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      act_cnt <= 32'h0;
      cur_op <= OP_WORD;
    end else begin
      if (start_ok) cur_op <= cmd_op;
      if (start_ok) act_cnt <= 32'h0;
      else if (busy) act_cnt <= act_cnt + 32'h1;
    end
  end

  property p_erase_max;
    @(posedge clk_sys) disable iff (!rstn) busy && cur_op == OP_ERASE |-> act_cnt < ERASE_CYC;
  endproperty
  a_erase_max: assert property (p_erase_max) else $error("erase exceeds its limit");

  property p_preprog_first;
    @(posedge clk_sys) disable iff (!rstn) erase_active |-> !preprog_valid && pre_last;
  endproperty
  a_preprog_first: assert property (p_preprog_first) else $error("erase began before pre-program");

  property p_word_max;
    @(posedge clk_sys) disable iff (!rstn) busy && cur_op == OP_WORD |-> act_cnt < PROG_CYC;
  endproperty
  a_word_max: assert property (p_word_max) else $error("word program too long");

  property p_buf_max;
    @(posedge clk_sys) disable iff (!rstn) busy && cur_op == OP_BUF |-> act_cnt < PROG_CYC;
  endproperty
  a_buf_max: assert property (p_buf_max) else $error("buffer program too long");

  property p_sect_prog;
    @(posedge clk_sys) disable iff (!rstn)
      op_done && cur_op == OP_BUF |->
        40'(act_cnt) * 40'((SECTOR_WORDS + `FET_BUF_WORDS - 1) / `FET_BUF_WORDS) <= 40'(SECT_PROG_CYC);
  endproperty
  a_sect_prog: assert property (p_sect_prog) else $error("sector program budget exceeded");

  property p_susp_ready;
    @(posedge clk_sys) disable iff (!rstn) susp_ok |=> suspended && !busy && !op_done;
  endproperty
  a_susp_ready: assert property (p_susp_ready) else $error("suspend not honoured");

  property p_eval_max;
    @(posedge clk_sys) disable iff (!rstn) busy && cur_op == OP_EVAL |-> act_cnt < EES_CYC;
  endproperty
  a_eval_max: assert property (p_eval_max) else $error("status evaluation too long");

  property p_nvr_wear;
    @(posedge clk_sys) disable iff (!rstn) start_ok && cmd_op == OP_NVR |=> nvr_pe_count == $past(nvr_pe_count) + 32'h1;
  endproperty
  a_nvr_wear: assert property (p_nvr_wear) else $error("register write did not wear array");

  property p_otp_nowear;
    @(posedge clk_sys) disable iff (!rstn) start_ok && cmd_op == OP_OTP |=> $stable(nvr_pe_count);
  endproperty
  a_otp_nowear: assert property (p_otp_nowear) else $error("otp write wore register array");

  property p_busy_span;
    @(posedge clk_sys) disable iff (!rstn) start_ok |=> busy && !op_done ##1 (busy || suspended);
  endproperty
  a_busy_span: assert property (p_busy_span) else $error("busy not shown during operation");

endmodule // fet_seq

// *** sim/fet_host.sv ***
/*
  host controller model issuing decoded command strobes.
  assumes the sequencer samples cmd_valid on rising clk_sys.
*/
`timescale 1ns/10ps

module fet_host
  import fet_pkg::*;
(
  // clock and bus mode
  input wire logic clk_sys,
  input wire logic byte_mode,
  // command strobe
  output logic cmd_valid,
  output fet_op_t cmd_op,
  output logic [25:0] cmd_addr,
  output logic [8:0] cmd_words
);
  int gap = 100;

  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_WORD;
    cmd_addr = '0;
    cmd_words = '0;
  end

  always @(posedge clk_sys) begin
    gap <= (cmd_valid && cmd_op == OP_RESUME) ? 0 : gap + 1;
  end

  // rude skips the host's own guards, for refusal tests only
  task automatic send(input fet_op_t op, input logic [25:0] addr, input logic [8:0] words, input bit rude);
    @(posedge clk_sys);
    while (op == OP_SUSPEND && gap < 6 && !rude) @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_words <= (byte_mode && op == OP_BUF && words == 9'h100 && !rude) ? 9'h080 : words;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    // released address and word lines carry no stale value
    cmd_addr <= ~addr;
    cmd_words <= ~words;
  endtask
endmodule // fet_host

// *** sim/flash_embedded_op_timing_test.sv ***
/*
  self-checking bench of the embedded operation sequencer.
  assumes short sim counts; the host model drives all commands.
*/
`timescale 1ns/10ps

module flash_embedded_op_timing_test
  import fet_pkg::*;
;
  localparam int PC = 50;
  localparam int EC = 400;
  localparam int SW = 64;
  typedef struct {fet_op_t op; logic [8:0] w; bit bm; bit rude; logic rej; int dur; int np; int dn;} fet_row_t;
  logic clk_sys, rstn, byte_mode, cmd_valid, busy, suspended, op_done, cmd_reject, preprog_valid, erase_active;
  fet_op_t cmd_op;
  logic [25:0] cmd_addr, preprog_addr;
  logic [8:0] cmd_words;
  logic [15:0] preprog_data;
  logic [31:0] nvr_pe_count;
  int fails = 0;
  int num_checks = 0;
  fet_row_t rows[13];
  int n;

  fet_host i_fet_host (.clk_sys(clk_sys), .byte_mode(byte_mode), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_words(cmd_words));
  fet_seq #(.SECTOR_WORDS(SW), .ERASE_CYC(32'd400), .PROG_CYC(32'd50), .SECT_PROG_CYC(32'd100)) i_fet_seq (
    .clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_words(cmd_words), .byte_mode(byte_mode), .busy(busy), .suspended(suspended), .op_done(op_done),
    .cmd_reject(cmd_reject), .preprog_valid(preprog_valid), .preprog_addr(preprog_addr),
    .preprog_data(preprog_data), .erase_active(erase_active), .nvr_pe_count(nvr_pe_count));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_idle;
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask

  task automatic run(input fet_row_t r, input logic [25:0] a);
    logic [31:0] c0;
    int np;
    c0 = nvr_pe_count;
    np = 0;
    n = 0;
    i_fet_host.send(r.op, a, r.w, r.rude);
    #1;
    chk(32'(cmd_reject), 32'(r.rej));
    while (busy === 1'b1 && n < 5000) begin
      if (preprog_valid === 1'b1) begin
        chk(32'(preprog_addr), 32'((a & ~26'(SW - 1)) + 26'(np)));
        chk(32'(preprog_data), 32'h0);
        np++;
      end
      chk(32'(erase_active), 32'(np == r.np && r.np != 0 && preprog_valid !== 1'b1));
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, r.dur);
    chk(np, r.np);
    chk(32'(op_done), 32'(r.dur != 0));
    chk(nvr_pe_count - c0, r.dn);
  endtask

  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    byte_mode = 1'b0;
    rows = '{'{OP_WORD, 1, 0, 0, 0, PC, 0, 0}, '{OP_BUF, 1, 0, 0, 0, PC, 0, 0}, '{OP_BUF, 256, 0, 0, 0, PC, 0, 0},
      '{OP_BUF, 256, 1, 1, 1, 0, 0, 0}, '{OP_BUF, 256, 1, 0, 0, PC, 0, 0}, '{OP_BUF, 0, 0, 0, 1, 0, 0, 0},
      '{OP_BUF, 257, 0, 0, 1, 0, 0, 0}, '{OP_NVR, 1, 0, 0, 0, PC, 0, 1}, '{OP_OTP, 1, 0, 0, 0, PC, 0, 0},
      '{OP_EVAL, 1, 0, 0, 0, 3000, 0, 0}, '{OP_ERASE, 1, 0, 0, 0, EC, SW, 0}, '{OP_RESUME, 1, 0, 0, 1, 0, 0, 0},
      '{OP_SUSPEND, 1, 0, 0, 1, 0, 0, 0}};
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({busy, suspended, op_done, cmd_reject, preprog_valid, erase_active}, 0);
    chk(nvr_pe_count, 0);
    $display("test reset done");
    // each row starts on its own 16-word line; the multi-word buffer rows run on over later lines
    for (int i = 0; i < 13; i++) begin
      @(posedge clk_sys);
      byte_mode <= rows[i].bm;
      run(rows[i], 26'(i * 16 + 7));
      $display("test %0d done", i);
    end
    i_fet_host.send(OP_WORD, 26'h300, 9'h1, 1'b0);
    repeat (10) @(posedge clk_sys);
    i_fet_host.send(OP_SUSPEND, 26'h0, 9'h1, 1'b0);
    #1;
    chk({busy, suspended}, 1);
    i_fet_host.send(OP_WORD, 26'h310, 9'h1, 1'b0);
    #1;
    chk(cmd_reject, 1);
    i_fet_host.send(OP_RESUME, 26'h0, 9'h1, 1'b0);
    #1;
    chk({busy, suspended}, 2);
    i_fet_host.send(OP_SUSPEND, 26'h0, 9'h1, 1'b1);
    #1;
    chk({cmd_reject, busy}, 3);
    i_fet_host.send(OP_SUSPEND, 26'h0, 9'h1, 1'b0);
    #1;
    chk({busy, suspended}, 1);
    i_fet_host.send(OP_RESUME, 26'h0, 9'h1, 1'b0);
    #1;
    wait_idle();
    // 12 + 8 active cycles ran before the last resume
    chk(n, PC - 20);
    chk(op_done, 1);
    $display("test suspend done");
    i_fet_host.send(OP_ERASE, 26'h3c0, 9'h1, 1'b0);
    repeat (5) @(posedge clk_sys);
    i_fet_host.send(OP_SUSPEND, 26'h0, 9'h1, 1'b0);
    #1;
    chk({busy, suspended, preprog_valid, erase_active}, 4);
    i_fet_host.send(OP_RESUME, 26'h0, 9'h1, 1'b0);
    #1;
    wait_idle();
    // 7 active cycles ran before the suspend
    chk(n, EC - 7);
    chk(op_done, 1);
    $display("test erase suspend done");
    i_fet_host.send(OP_NVR, 26'h320, 9'h1, 1'b0);
    rstn <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({busy, nvr_pe_count[3:0]}, 0);
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({busy, suspended, op_done, cmd_reject, preprog_valid, erase_active}, 0);
    i_fet_host.send(OP_NVR, 26'h330, 9'h1, 1'b0);
    #1;
    chk({busy, nvr_pe_count[3:0]}, 5'h11);
    $display("test mid reset done");
    print_verdict();
  end
endmodule // flash_embedded_op_timing_test
